// >>> sram_port_pkg.sv
package sram_port_pkg;

  // Array geometry and counter width
  localparam int LANES   = 4;
  localparam int LANE_W  = 8;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int WORD_W  = DATA_W + LANES;
  localparam int ADDR_W  = 8;
  localparam int CNT_W   = 16;

  // Register offsets (byte addresses)
  localparam logic [3:0] OFF_CTRL    = 4'h0;
  localparam logic [3:0] OFF_STATUS  = 4'h4;
  localparam logic [3:0] OFF_READS   = 4'h8;
  localparam logic [3:0] OFF_WRITES  = 4'hC;

  // Field positions
  localparam int CTRL_WPROT_BIT       = 0;
  localparam int STATUS_ACTIVE_BIT    = 0;
  localparam int STATUS_WRITE_BIT     = 1;
  localparam int STATUS_DRIVE_BIT     = 2;
  localparam int STATUS_INTERLEAV_BIT = 3;
  localparam int STATUS_LOW_POS       = 4;

  // Reset values
  localparam logic       CTRL_RESET  = 1'b0;
  localparam logic [1:0] BURST_START = 2'h0;
  localparam logic       STRAP_RESET = 1'b1;

  typedef enum {ACC_DESELECTED, ACC_READ, ACC_WRITE} access_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_write_select_n;
  } cmd_t;

  typedef struct packed {
    logic [LANES-1:0]  parity;
    logic [DATA_W-1:0] data;
  } word_t;

endpackage

// >>> burst_addr_gen.sv
`timescale 1ns/10ps
`default_nettype none

module burst_addr_gen (
  // Burst position
  input  wire logic [1:0] start_i,
  input  wire logic [1:0] count_i,
  // Order select
  input  wire logic       interleaved_i,
  // Stepped low address pair
  output logic      [1:0] low_o
);

  always_comb
  begin
    if (interleaved_i)
    begin
      low_o = start_i ^ count_i;
    end
    else
    begin
      low_o = 2'(start_i + count_i);
    end
  end

endmodule // burst_addr_gen

`default_nettype wire

// >>> sram_data_port.sv
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module sram_data_port (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // Memory controller side
  input  wire logic                                clock_gate_n_i,
  input  wire logic                                chip_select_first_n_i,
  input  wire logic                                chip_select_second_i,
  input  wire logic                                chip_select_third_n_i,
  input  wire logic                                write_enable_n_i,
  input  wire logic                                advance_or_load_i,
  input  wire logic [sram_port_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [sram_port_pkg::LANES-1:0]     byte_lane_write_select_n_i,
  input  wire logic                                output_enable_n_i,
  input  wire logic                                burst_mode_strap_i,
  // Data lanes
  input  wire logic [sram_port_pkg::DATA_W-1:0]    data_lanes_i,
  output logic      [sram_port_pkg::DATA_W-1:0]    data_lanes_o,
  output logic      [sram_port_pkg::DATA_W-1:0]    data_lanes_oe_o,
  // Parity lanes
  input  wire logic [sram_port_pkg::LANES-1:0]     parity_lanes_i,
  output logic      [sram_port_pkg::LANES-1:0]     parity_lanes_o,
  output logic      [sram_port_pkg::LANES-1:0]     parity_lanes_oe_o,
  // Wishbone slave
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [3:0]                          wb_adr_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic [31:0]                         wb_dat_i,
  output logic      [31:0]                         wb_dat_o,
  output logic                                     wb_ack_o
);

  localparam int DEPTH = 1 << sram_port_pkg::ADDR_W;

  function automatic sram_port_pkg::word_t merge_lanes(
    input sram_port_pkg::word_t                   old_word,
    input sram_port_pkg::word_t                   new_word,
    input logic [sram_port_pkg::LANES-1:0]        sel_n
  );
    sram_port_pkg::word_t w;
    w = old_word;
    for (int i = 0; i < sram_port_pkg::LANES; i++)
    begin
      if (!sel_n[i])
      begin
        w.data[i*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] =
          new_word.data[i*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
        w.parity[i] = new_word.parity[i];
      end
    end
    return w;
  endfunction

  // Asynchronous pins: output enable and strap
  logic oe_meta;
  logic oe_sync;
  logic strap_meta;
  logic strap_sync;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      oe_meta    <= 1'b1;
      oe_sync    <= 1'b1;
      strap_meta <= sram_port_pkg::STRAP_RESET;
      strap_sync <= sram_port_pkg::STRAP_RESET;
    end
    else
    begin
      oe_meta    <= output_enable_n_i;
      oe_sync    <= oe_meta;
      strap_meta <= burst_mode_strap_i;
      strap_sync <= strap_meta;
    end
  end

  // Clock qualification
  logic edge_en;
  assign edge_en = !clock_gate_n_i;

  // Access state and burst counter
  sram_port_pkg::access_t              access;
  sram_port_pkg::access_t              next_access;
  logic [sram_port_pkg::ADDR_W-1:0]    base_addr;
  logic [sram_port_pkg::ADDR_W-1:0]    next_base_addr;
  logic [1:0]                          burst_count;
  logic [1:0]                          next_burst_count;
  logic [sram_port_pkg::LANES-1:0]     lane_sel_n;
  logic [sram_port_pkg::LANES-1:0]     next_lane_sel_n;
  logic                                selected;
  logic [1:0]                          burst_low;

  assign selected = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;

  burst_addr_gen u_burst (
    .start_i       (base_addr[1:0]),
    .count_i       (burst_count),
    .interleaved_i (strap_sync),
    .low_o         (burst_low)
  );

  always_comb
  begin
    next_access      = access;
    next_base_addr   = base_addr;
    next_burst_count = burst_count;
    next_lane_sel_n  = lane_sel_n;
    if (edge_en)
    begin
      if (!advance_or_load_i)
      begin
        next_base_addr   = addr_i;
        next_burst_count = sram_port_pkg::BURST_START;
        next_lane_sel_n  = byte_lane_write_select_n_i;
        if (!selected)
        begin
          next_access = sram_port_pkg::ACC_DESELECTED;
        end
        else if (write_enable_n_i)
        begin
          next_access = sram_port_pkg::ACC_READ;
        end
        else
        begin
          next_access = sram_port_pkg::ACC_WRITE;
        end
      end
      else
      begin
        next_burst_count = 2'(burst_count + 2'h1);
        next_lane_sel_n  = byte_lane_write_select_n_i;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      access      <= sram_port_pkg::ACC_DESELECTED;
      base_addr   <= '0;
      burst_count <= sram_port_pkg::BURST_START;
      lane_sel_n  <= '1;
    end
    else
    begin
      access      <= next_access;
      base_addr   <= next_base_addr;
      burst_count <= next_burst_count;
      lane_sel_n  <= next_lane_sel_n;
    end
  end

  // Current access as a command
  sram_port_pkg::cmd_t cur_cmd;

  always_comb
  begin
    cur_cmd.valid = 1'b0;
    cur_cmd.write = 1'b0;
    case (access)
      sram_port_pkg::ACC_READ:
      begin
        cur_cmd.valid = 1'b1;
      end
      sram_port_pkg::ACC_WRITE:
      begin
        cur_cmd.valid = 1'b1;
        cur_cmd.write = 1'b1;
      end
      default:
      begin
        cur_cmd.valid = 1'b0;
      end
    endcase
    cur_cmd.addr = {base_addr[sram_port_pkg::ADDR_W-1:2], burst_low};
    cur_cmd.lane_write_select_n = lane_sel_n;
  end

  // Pipeline, array and output register
  sram_port_pkg::cmd_t   write_cmd;
  sram_port_pkg::cmd_t   next_write_cmd;
  sram_port_pkg::word_t  mem [DEPTH];
  sram_port_pkg::word_t  in_word;
  sram_port_pkg::word_t  merged_word;
  sram_port_pkg::word_t  read_word;
  sram_port_pkg::word_t  out_word;
  sram_port_pkg::word_t  next_out_word;
  sram_port_pkg::word_t  captured;
  sram_port_pkg::word_t  next_captured;
  logic                  write_protect;
  logic                  write_now;
  logic                  read_phase;
  logic                  next_read_phase;
  logic                  drive;
  logic                  next_drive;

  assign in_word.data   = data_lanes_i;
  assign in_word.parity = parity_lanes_i;
  assign merged_word    = merge_lanes(mem[write_cmd.addr], in_word,
                                      write_cmd.lane_write_select_n);
  assign write_now      = edge_en && write_cmd.valid && write_cmd.write && !write_protect;

  always_comb
  begin
    next_write_cmd  = write_cmd;
    next_out_word   = out_word;
    next_captured   = captured;
    next_read_phase = read_phase;
    read_word       = mem[cur_cmd.addr];
    if (write_now && write_cmd.addr == cur_cmd.addr)
    begin
      read_word = merged_word;
    end
    if (edge_en)
    begin
      next_write_cmd  = cur_cmd;
      next_captured   = in_word;
      next_read_phase = cur_cmd.valid && !cur_cmd.write;
      if (cur_cmd.valid && !cur_cmd.write)
      begin
        next_out_word = read_word;
      end
    end
    next_drive = next_read_phase && !oe_sync;
  end

  always_ff @(posedge clk_i)
  begin
    if (write_now)
    begin
      mem[write_cmd.addr] <= merged_word;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      write_cmd  <= '0;
      out_word   <= '0;
      captured   <= '0;
      read_phase <= 1'b0;
      drive      <= 1'b0;
    end
    else
    begin
      write_cmd  <= next_write_cmd;
      out_word   <= next_out_word;
      captured   <= next_captured;
      read_phase <= next_read_phase;
      drive      <= next_drive;
    end
  end

  // Lane drivers, one flop per pin
  logic [sram_port_pkg::DATA_W-1:0] data_oe;
  logic [sram_port_pkg::LANES-1:0]  parity_oe;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_oe   <= '0;
      parity_oe <= '0;
    end
    else
    begin
      data_oe   <= {sram_port_pkg::DATA_W{next_drive}};
      parity_oe <= {sram_port_pkg::LANES{next_drive}};
    end
  end

  assign data_lanes_o      = out_word.data;
  assign parity_lanes_o    = out_word.parity;
  assign data_lanes_oe_o   = data_oe;
  assign parity_lanes_oe_o = parity_oe;

  // Activity counters
  logic [sram_port_pkg::CNT_W-1:0] read_count;
  logic [sram_port_pkg::CNT_W-1:0] next_read_count;
  logic [sram_port_pkg::CNT_W-1:0] write_count;
  logic [sram_port_pkg::CNT_W-1:0] next_write_count;

  always_comb
  begin
    next_read_count  = read_count;
    next_write_count = write_count;
    if (edge_en && cur_cmd.valid && !cur_cmd.write)
    begin
      next_read_count = read_count + 1'b1;
    end
    if (write_now)
    begin
      next_write_count = write_count + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      read_count  <= '0;
      write_count <= '0;
    end
    else
    begin
      read_count  <= next_read_count;
      write_count <= next_write_count;
    end
  end

  // Wishbone register slave
  logic        next_write_protect;
  logic [31:0] next_wb_dat;
  logic        next_wb_ack;
  logic        wb_req;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb
  begin
    next_write_protect = write_protect;
    next_wb_dat        = 32'h0000_0000;
    next_wb_ack        = wb_req;
    if (wb_req && wb_we_i && wb_adr_i == sram_port_pkg::OFF_CTRL && wb_sel_i[0])
    begin
      next_write_protect = wb_dat_i[sram_port_pkg::CTRL_WPROT_BIT];
    end
    if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        sram_port_pkg::OFF_CTRL:
        begin
          next_wb_dat[sram_port_pkg::CTRL_WPROT_BIT] = write_protect;
        end
        sram_port_pkg::OFF_STATUS:
        begin
          next_wb_dat[sram_port_pkg::STATUS_ACTIVE_BIT]    = cur_cmd.valid;
          next_wb_dat[sram_port_pkg::STATUS_WRITE_BIT]     = cur_cmd.write;
          next_wb_dat[sram_port_pkg::STATUS_DRIVE_BIT]     = drive;
          next_wb_dat[sram_port_pkg::STATUS_INTERLEAV_BIT] = strap_sync;
          next_wb_dat[sram_port_pkg::STATUS_LOW_POS +: 2]  = burst_low;
        end
        sram_port_pkg::OFF_READS:
        begin
          next_wb_dat[sram_port_pkg::CNT_W-1:0] = read_count;
        end
        sram_port_pkg::OFF_WRITES:
        begin
          next_wb_dat[sram_port_pkg::CNT_W-1:0] = write_count;
        end
        default:
        begin
          next_wb_dat = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      write_protect <= sram_port_pkg::CTRL_RESET;
      wb_dat_o      <= 32'h0000_0000;
      wb_ack_o      <= 1'b0;
    end
    else
    begin
      write_protect <= next_write_protect;
      wb_dat_o      <= next_wb_dat;
      wb_ack_o      <= next_wb_ack;
    end
  end

endmodule // sram_data_port

`default_nettype wire

// >>> sram_port_checker_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module sram_port_checker (
  // Clock
  input wire logic                             clk_i,
  input wire logic                             rst_i,
  // Controller
  input wire logic                             clock_gate_n_i,
  input wire logic                             chip_select_first_n_i,
  input wire logic                             chip_select_second_i,
  input wire logic                             chip_select_third_n_i,
  input wire logic                             write_enable_n_i,
  input wire logic                             advance_or_load_i,
  input wire logic                             output_enable_n_i,
  // Lanes
  input wire logic [sram_port_pkg::DATA_W-1:0] data_lanes_o,
  input wire logic [sram_port_pkg::DATA_W-1:0] data_lanes_oe_o,
  input wire logic [sram_port_pkg::LANES-1:0]  parity_lanes_oe_o,
  // Wishbone
  input wire logic                             wb_cyc_i,
  input wire logic                             wb_stb_i,
  input wire logic                             wb_we_i,
  input wire logic [3:0]                       wb_adr_i,
  input wire logic [31:0]                      wb_dat_o,
  input wire logic                             wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic sel;
  logic load;
  logic wb_req;
  assign sel = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;
  assign load = !clock_gate_n_i && !advance_or_load_i;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  property p_oe_masked;
    output_enable_n_i [*4] |-> data_lanes_oe_o == '0 && parity_lanes_oe_o == '0;
  endproperty
  a_oe_masked: assert property (p_oe_masked)
    else $error("lanes driven with output enable high");
  property p_lanes_agree;
    data_lanes_oe_o == {32{parity_lanes_oe_o[0]}} && parity_lanes_oe_o == {4{parity_lanes_oe_o[0]}};
  endproperty
  a_lanes_agree: assert property (p_lanes_agree)
    else $error("parity and data drive enables differ");
  property p_gate_freeze;
    clock_gate_n_i |=> $stable(data_lanes_o);
  endproperty
  a_gate_freeze: assert property (p_gate_freeze)
    else $error("read data changed on a gated edge");
  property p_gate_keeps_select;
    (!output_enable_n_i) [*4] ##0 clock_gate_n_i |=> $stable(data_lanes_oe_o);
  endproperty
  a_gate_keeps_select: assert property (p_gate_keeps_select)
    else $error("drive state changed while clock gated");
  property p_write_off;
    (load && sel && !write_enable_n_i) ##1 !clock_gate_n_i |=> data_lanes_oe_o == '0;
  endproperty
  a_write_off: assert property (p_write_off)
    else $error("lanes driven in write data cycle");
  property p_desel_off;
    (load && !sel) ##1 !clock_gate_n_i |=> data_lanes_oe_o == '0;
  endproperty
  a_desel_off: assert property (p_desel_off)
    else $error("lanes driven after deselect");
  property p_read_drives;
    (!output_enable_n_i) [*4] ##0 (load && sel && write_enable_n_i) ##1 !clock_gate_n_i
      |=> data_lanes_oe_o == '1;
  endproperty
  a_read_drives: assert property (p_read_drives)
    else $error("read data not driven");
  property p_ack_once;
    wb_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("bus ack not a single pulse");
  property p_unmapped_zero;
    (wb_req && !wb_we_i && wb_adr_i[1:0] != 2'h0) |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  c_read: cover property (load && sel && write_enable_n_i);
  c_write: cover property (load && sel && !write_enable_n_i);
  c_stall: cover property (clock_gate_n_i [*3]);
endmodule // sram_port_checker

bind sram_data_port sram_port_checker u_chk (
  .clk_i, .rst_i, .clock_gate_n_i, .chip_select_first_n_i, .chip_select_second_i,
  .chip_select_third_n_i, .write_enable_n_i, .advance_or_load_i, .output_enable_n_i,
  .data_lanes_o, .data_lanes_oe_o, .parity_lanes_oe_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o
);

`default_nettype wire

// >>> sram_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

module sram_ctrl_model (
  // Clock
  input  wire logic                           clk_i,
  // Control to the port
  output logic                                clock_gate_n_o,
  output logic                                chip_select_first_n_o,
  output logic                                chip_select_second_o,
  output logic                                chip_select_third_n_o,
  output logic                                write_enable_n_o,
  output logic                                advance_or_load_o,
  output logic [sram_port_pkg::ADDR_W-1:0]    addr_o,
  output logic [sram_port_pkg::LANES-1:0]     byte_lane_write_select_n_o,
  output logic                                output_enable_n_o,
  output logic                                burst_mode_strap_o,
  // Shared lanes
  input  wire sram_port_pkg::word_t           port_word_i,
  input  wire logic                           port_drive_i,
  output var sram_port_pkg::word_t            lanes_o
);
  sram_port_pkg::word_t wdata;
  sram_port_pkg::word_t last;
  logic                 drive;

  initial
  begin
    {clock_gate_n_o, chip_select_first_n_o, chip_select_second_o, chip_select_third_n_o} = 4'h5;
    {write_enable_n_o, advance_or_load_o, output_enable_n_o, burst_mode_strap_o} = 4'hB;
    addr_o = 8'h00;
    byte_lane_write_select_n_o = 4'hF;
    wdata = '0;
    last = '0;
    drive = 1'b0;
  end

  // Released lanes flip every cycle so a stale value is never read back
  always_comb
  begin
    if (port_drive_i)
      lanes_o = port_word_i;
    else if (drive)
      lanes_o = wdata;
    else
      lanes_o = ~last;
  end
  always @(posedge clk_i)
    last <= lanes_o;

  task automatic cmd(input logic s, input logic w_n, input logic adv, input logic [7:0] a,
                     input logic [3:0] bw);
    @(posedge clk_i);
    chip_select_first_n_o <= !s;
    chip_select_second_o <= s;
    chip_select_third_n_o <= !s;
    write_enable_n_o <= w_n;
    advance_or_load_o <= adv;
    addr_o <= a;
    byte_lane_write_select_n_o <= bw;
  endtask

  // Holds the current cycle for n edges
  task automatic stall(input int n);
    clock_gate_n_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    clock_gate_n_o <= 1'b0;
  endtask

  task automatic write(input logic [7:0] a, input logic [3:0] bw, input sram_port_pkg::word_t w);
    cmd(1'b1, 1'b0, 1'b0, a, bw);
    cmd(1'b0, 1'b1, 1'b0, a, 4'hF);
    @(posedge clk_i);
    wdata <= w;
    drive <= 1'b1;
    @(posedge clk_i);
    drive <= 1'b0;
  endtask

  // Strap and output enable change only while the port is idle
  task automatic settle(input logic oe_n, input logic strap);
    @(posedge clk_i);
    output_enable_n_o <= oe_n;
    burst_mode_strap_o <= strap;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // sram_ctrl_model

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 wb_cyc = 1'b0;
  logic                 wb_stb = 1'b0;
  logic                 wb_we = 1'b0;
  logic [3:0]           wb_adr = 4'h0;
  logic [3:0]           wb_sel = 4'h0;
  logic [31:0]          wb_wdat = 32'h0;
  wire logic [31:0]     wb_rdat;
  wire logic            wb_ack;
  wire logic            gate_n, cs1_n, cs2, cs3_n, we_n, adv, oe_n, strap;
  wire logic [7:0]      addr;
  wire logic [3:0]      bw_n, par_o, par_oe;
  wire logic [31:0]     dq_o, dq_oe;
  wire sram_port_pkg::word_t bus;
  sram_port_pkg::word_t mem [256];
  int                   bad_count = 0;
  int                   samples_checked = 0;

  always #10 clk_i = ~clk_i;

  sram_ctrl_model ctl (.clk_i(clk_i), .clock_gate_n_o(gate_n), .chip_select_first_n_o(cs1_n),
    .chip_select_second_o(cs2), .chip_select_third_n_o(cs3_n), .write_enable_n_o(we_n),
    .advance_or_load_o(adv), .addr_o(addr), .byte_lane_write_select_n_o(bw_n),
    .output_enable_n_o(oe_n), .burst_mode_strap_o(strap), .port_word_i({par_o, dq_o}),
    .port_drive_i(dq_oe[0]), .lanes_o(bus));

  sram_data_port uut (.clk_i(clk_i), .rst_i(rst_i), .clock_gate_n_i(gate_n),
    .chip_select_first_n_i(cs1_n), .chip_select_second_i(cs2), .chip_select_third_n_i(cs3_n),
    .write_enable_n_i(we_n), .advance_or_load_i(adv), .addr_i(addr),
    .byte_lane_write_select_n_i(bw_n), .output_enable_n_i(oe_n), .burst_mode_strap_i(strap),
    .data_lanes_i(bus.data), .data_lanes_o(dq_o), .data_lanes_oe_o(dq_oe),
    .parity_lanes_i(bus.parity), .parity_lanes_o(par_o), .parity_lanes_oe_o(par_oe),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));

  task automatic report_and_stop();
    $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                    input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_wdat <= d;
    @(posedge clk_i);
    while (wb_ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (wb_ack !== 1'b1)
    begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, wb_ack, 1'b1);
    end
    if (!we)
      check({4'h0, wb_rdat}, {4'h0, exp});
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] bw, input sram_port_pkg::word_t w);
    ctl.write(a, bw, w);
    for (int i = 0; i < 4; i++)
      if (!bw[i])
      begin
        mem[a].data[8*i +: 8] = w.data[8*i +: 8];
        mem[a].parity[i] = w.parity[i];
      end
  endtask

  // Load at a, then n-1 advances, n beats in all; the output of each beat is checked one edge later
  task automatic rd(input logic [7:0] a, input int n, input logic lin, input logic on);
    logic [1:0] low;
    ctl.cmd(1'b1, 1'b1, 1'b0, a, 4'hF);
    for (int k = 0; k <= n; k++)
    begin
      ctl.cmd(k < n - 1, 1'b1, k < n - 1, a, 4'hF);
      if (k == 2)
        ctl.stall(3);
      @(negedge clk_i);
      low = lin ? a[1:0] + 2'(k - 1) : a[1:0] ^ 2'(k - 1);
      if (k > 0)
        check({par_oe, dq_oe}, {36{on}});
      if (k > 0 && on)
        check({par_o, dq_o}, mem[{a[7:2], low}]);
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check({par_oe, dq_oe}, 36'h0);
    ctl.settle(1'b0, 1'b1);
    for (int i = 0; i < 4; i++)
      wr(8'h20 + 8'(i), 4'h0, {4'(i + 5), 32'h5A3C_0000 + 32'(i)});
    wr(8'h22, 4'h5, 36'hF_0F0F_0F0F);
    rd(8'h21, 4, 1'b0, 1'b1);
    ctl.settle(1'b0, 1'b0);
    rd(8'h23, 4, 1'b1, 1'b1);
    ctl.settle(1'b1, 1'b1);
    rd(8'h20, 1, 1'b0, 1'b0);
    ctl.settle(1'b0, 1'b1);
    wb(1'b1, 4'h2, 32'hFFFF_FFFF, 32'h0);
    wb(1'b0, 4'h2, 32'h0, 32'h0);
    wb(1'b1, 4'h0, 32'h1, 32'h0);
    wb(1'b0, 4'h0, 32'h0, 32'h1);
    ctl.write(8'h20, 4'h0, 36'h0);
    rd(8'h20, 1, 1'b0, 1'b1);
    wb(1'b1, 4'h0, 32'h0, 32'h0);
    wb(1'b0, 4'h4, 32'h0, 32'h0000_0008);
    wb(1'b0, 4'h8, 32'h0, 32'h0000_000A);
    wb(1'b0, 4'hC, 32'h0, 32'h0000_0005);
    report_and_stop();
  end

  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
